// ---- hw/csd_command_decoder.sv ----
// command strobe decoder: fifo commands, sync strobe and test reset
`timescale 1ns/1ps
`default_nettype none

module csd_command_decoder
  import csd_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output var  logic [31:0]       rdata,
  input  wire logic              input_sample_clock,
  input  wire logic              sampleStored,
  input  wire logic [2:0]        fifoThreshold,
  output var  logic              sync_strobe_out,
  output var  csd_fifo_type      fifo,
  output var  logic              fifo_interrupt,
  output var  csd_stage_type     stage
);

  typedef struct packed {
    logic [31:0]   rdata;
    logic [31:0]   config0;
    logic [9:0]    phaseOffset;
    csd_fifo_type  fifo;
    csd_stage_type stage;
    logic          feedbackPending;
  } csd_state_type;

  csd_state_type st;
  csd_state_type next_st;

  logic [5:0]    index;
  logic          aligned;
  logic          hitPtrReset;
  logic          hitAdvance;
  logic          hitSync;
  logic          hitTest;
  logic          doAdvance;
  logic          doStore;
  logic [3:0]    newDepth;
  logic          syncPulse;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode; command writes look at the address only
  assign index       = addr[7:2];
  assign aligned     = (addr[1:0] == 2'h0);
  assign hitPtrReset = wr && aligned && (index == CSD_IDX_FIFO_PTR_RST);
  assign hitAdvance  = wr && aligned && (index == CSD_IDX_FIFO_ADVANCE);
  assign hitSync     = wr && aligned && (index == CSD_IDX_SYNC_PULSE);
  assign hitTest     = wr && aligned && (index == CSD_IDX_TEST_RESET);

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_st   = st;
    doAdvance = 1'b0;
    doStore   = 1'b0;
    newDepth  = st.fifo.depth;

    // stage strobes last one cycle
    next_st.stage.ncoPhaseLoad  = 1'b0;
    next_st.stage.cicClear      = 1'b0;
    next_st.stage.halfbandClear = 1'b0;
    next_st.feedbackPending     = 1'b0;

    // read data stands only in the cycle after the strobe
    next_st.rdata = 32'h0000_0000;
    if (rd && aligned)
    begin
      unique case (index)
        CSD_IDX_CONFIG0:
        begin
          next_st.rdata = st.config0;
        end
        CSD_IDX_PHASE_OFFSET:
        begin
          next_st.rdata = {22'h00_0000, st.phaseOffset};
        end
        CSD_IDX_STATUS:
        begin
          next_st.rdata = {17'h0, st.stage.ncoFeedbackEnable, st.fifo.interrupt,
                           st.fifo.ready, st.fifo.full, st.fifo.empty, st.fifo.depth,
                           st.fifo.writePtr, st.fifo.readPtr};
        end
        default:
        begin
          next_st.rdata = 32'h0000_0000;        // unmapped and write-only words
        end
      endcase
    end

    // plain configuration registers
    if (wr && aligned && index == CSD_IDX_CONFIG0)
    begin
      next_st.config0 = wdata;
    end
    if (wr && aligned && index == CSD_IDX_PHASE_OFFSET)
    begin
      next_st.phaseOffset = wdata[CSD_PHASE_W-1:0];
    end

    // fifo bookkeeping on the processing clock
    doAdvance = hitAdvance && !st.fifo.empty;
    doStore   = sampleStored && !st.fifo.full;
    if (doAdvance)
    begin
      next_st.fifo.readPtr = st.fifo.readPtr + 3'h1;
    end
    if (doStore)
    begin
      next_st.fifo.writePtr = st.fifo.writePtr + 3'h1;
    end
    if (doStore && !doAdvance)
    begin
      newDepth = st.fifo.depth + 4'h1;
    end
    else if (doAdvance && !doStore)
    begin
      newDepth = st.fifo.depth - 4'h1;
    end
    next_st.fifo.depth = newDepth;
    next_st.fifo.empty = (newDepth == 4'h0);
    next_st.fifo.full  = (newDepth == CSD_FIFO_SLOTS);
    next_st.fifo.ready = (newDepth >= {1'b0, fifoThreshold});
    // interrupt set when filling reaches the threshold, held until a read advance, pointer reset or test reset
    if (doStore && !doAdvance && newDepth == {1'b0, fifoThreshold})
    begin
      next_st.fifo.interrupt = 1'b1;
    end
    else if (doAdvance)
    begin
      next_st.fifo.interrupt = 1'b0;
    end

    // pointer reset command
    if (hitPtrReset)
    begin
      next_st.fifo.readPtr  = CSD_RD_PTR_INIT;
      next_st.fifo.writePtr = CSD_WR_PTR_INIT;
      next_st.fifo.depth    = 4'h0;
      next_st.fifo.empty    = 1'b1;
      next_st.fifo.full     = 1'b0;
      next_st.fifo.ready    = 1'b0;
      next_st.fifo.interrupt = 1'b0;
    end

    // test reset of counters and accumulators
    if (hitTest)
    begin
      next_st.stage.ncoPhaseLoad      = 1'b1;
      next_st.stage.ncoPhaseValue     = st.phaseOffset;
      next_st.stage.ncoFeedbackEnable = 1'b0;
      next_st.feedbackPending         = 1'b1;
      next_st.stage.cicClear          = 1'b1;
      next_st.stage.halfbandClear     = 1'b1;
      next_st.fifo.readPtr            = CSD_RD_PTR_INIT;
      next_st.fifo.writePtr           = CSD_WR_PTR_INIT;
      next_st.fifo.depth              = 4'h0;
      next_st.fifo.full               = 1'b0;
      next_st.fifo.empty              = 1'b1;
      next_st.fifo.ready              = 1'b0;
      next_st.fifo.interrupt          = 1'b0;
    end
    else if (st.feedbackPending)
    begin
      next_st.stage.ncoFeedbackEnable = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st                        <= '0;
      st.config0                <= CSD_CONFIG0_RST;
      st.phaseOffset            <= CSD_PHASE_RST;
      st.fifo.readPtr           <= CSD_RD_PTR_INIT;
      st.fifo.writePtr          <= CSD_WR_PTR_INIT;
      st.fifo.empty             <= 1'b1;
      st.stage.ncoFeedbackEnable <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sync strobe pin
  csd_sync_strobe u_sync (
    .clk              (clk),
    .rst              (rst),
    .fire             (hitSync),
    .useSampleClock   (st.config0[CSD_CFG0_SYNC_SEL_BIT]),
    .inputSampleClock (input_sample_clock),
    .strobe           (syncPulse)
  );

  // outputs straight from flip-flops
  assign rdata           = st.rdata;
  assign fifo            = st.fifo;
  assign fifo_interrupt  = st.fifo.interrupt;
  assign stage           = st.stage;
  assign sync_strobe_out = syncPulse;

endmodule : csd_command_decoder

`default_nettype wire

// ---- hw/csd_pkg.sv ----
// constants and carrier types for the command strobe decoder
package csd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register word indices; byte address is four times the index
  localparam logic [5:0] CSD_IDX_CONFIG0       = 6'h00;
  localparam logic [5:0] CSD_IDX_FIFO_PTR_RST  = 6'h16;
  localparam logic [5:0] CSD_IDX_FIFO_ADVANCE  = 6'h17;
  localparam logic [5:0] CSD_IDX_SYNC_PULSE    = 6'h18;
  localparam logic [5:0] CSD_IDX_TEST_RESET    = 6'h19;
  localparam logic [5:0] CSD_IDX_PHASE_OFFSET  = 6'h1C;
  localparam logic [5:0] CSD_IDX_STATUS        = 6'h1F;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions and widths
  localparam int         CSD_CFG0_SYNC_SEL_BIT = 3;
  localparam int         CSD_PHASE_W           = 10;
  localparam int         CSD_PTR_W             = 3;
  localparam int         CSD_DEPTH_W           = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // reset and command values
  localparam logic [31:0] CSD_CONFIG0_RST      = 32'h0000_0000;
  localparam logic [9:0]  CSD_PHASE_RST        = 10'h000;
  localparam logic [2:0]  CSD_RD_PTR_INIT      = 3'h7;
  localparam logic [2:0]  CSD_WR_PTR_INIT      = 3'h0;
  localparam logic [3:0]  CSD_FIFO_SLOTS       = 4'h8;
  localparam logic [3:0]  CSD_THRESH_RST       = 4'h4;

  ////////////////////////////////////////////////////////////////////////////////
  // register port carrier
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } csd_bus_req_type;

  // output fifo control state shown to the datapath
  typedef struct packed {
    logic [2:0] readPtr;
    logic [2:0] writePtr;
    logic [3:0] depth;
    logic       empty;
    logic       full;
    logic       ready;
    logic       interrupt;
  } csd_fifo_type;

  // test reset strobes towards the processing stages
  typedef struct packed {
    logic       ncoPhaseLoad;
    logic [9:0] ncoPhaseValue;
    logic       ncoFeedbackEnable;
    logic       cicClear;
    logic       halfbandClear;
  } csd_stage_type;

endpackage : csd_pkg

// ---- hw/csd_sync_strobe.sv ----
// sync strobe generator timed by processing clock or input sample clock
`timescale 1ns/1ps
`default_nettype none

module csd_sync_strobe
  import csd_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic fire,
  input  wire logic useSampleClock,
  input  wire logic inputSampleClock,
  output var  logic strobe
);

  typedef struct packed {
    logic armed;
    logic lastSample;
    logic useSample;
    logic strobe;
  } csd_sync_state_type;

  csd_sync_state_type st;
  csd_sync_state_type next_st;
  logic               sampleRise;

  ////////////////////////////////////////////////////////////////////////////////
  // next state: one clk wide pulse, or one input sample period wide pulse
  always_comb
  begin
    next_st            = st;
    sampleRise         = inputSampleClock & ~st.lastSample;
    next_st.lastSample = inputSampleClock;
    if (fire && !st.strobe && !st.armed)
    begin
      if (useSampleClock)
      begin
        next_st.armed     = 1'b1;                // wait for next sample clock edge
        next_st.useSample = 1'b1;
      end
      else
      begin
        next_st.strobe    = 1'b1;
        next_st.useSample = 1'b0;
      end
    end
    else if (st.strobe && !st.useSample)
    begin
      next_st.strobe = 1'b0;
    end
    else if (st.useSample && sampleRise)
    begin
      if (st.armed)
      begin
        next_st.armed  = 1'b0;
        next_st.strobe = 1'b1;
      end
      else if (st.strobe)
      begin
        next_st.strobe    = 1'b0;
        next_st.useSample = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign strobe = st.strobe;

endmodule : csd_sync_strobe

`default_nettype wire

// ---- verif/csd_command_decoder_chk.sv ----
// concurrent checks on the command strobe decoder ports
`timescale 1ns/1ps
`default_nettype none

module csd_command_decoder_chk
  import csd_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0]       wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [31:0]       rdata,
  input wire logic              input_sample_clock,
  input wire logic              sampleStored,
  input wire logic [2:0]        fifoThreshold,
  input wire logic              sync_strobe_out,
  input wire csd_fifo_type      fifo,
  input wire logic              fifo_interrupt,
  input wire csd_stage_type     stage
);
  logic       cfgSel;
  logic [9:0] phase;

  ////////////////////////////////////////////////////////////////////////////////
  // shadow copies of sync timing select and phase offset
  always_ff @(posedge clk)
    if (rst)
    begin
      cfgSel <= 1'b0;
      phase  <= 10'h000;
    end
    else if (wr && addr == 8'h00)
      cfgSel <= wdata[3];
    else if (wr && addr == 8'h70)
      phase <= wdata[9:0];

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // command effects
  ptr_reset_a: assert property (wr && addr == 8'h58 |=> fifo.readPtr == 3'h7
    && fifo.writePtr == 3'h0 && fifo.depth == 4'h0 && fifo.empty) else $error("pointer reset");
  advance_step_a: assert property (wr && addr == 8'h5C && !fifo.empty && !sampleStored
    |=> fifo.readPtr == $past(fifo.readPtr) + 3'h1 && fifo.depth == $past(fifo.depth) - 4'h1)
    else $error("advance step");
  sync_proc_a: assert property (wr && addr == 8'h60 && !cfgSel && !sync_strobe_out
    |=> sync_strobe_out ##1 !sync_strobe_out) else $error("sync pulse timing");
  sync_width_a: assert property ($rose(sync_strobe_out) && !cfgSel |=> !sync_strobe_out)
    else $error("sync pulse width");
  sync_sample_a: assert property ($rose(sync_strobe_out) && cfgSel
    |-> $past(input_sample_clock) || $past(input_sample_clock, 2)) else $error("sync source");
  test_stage_a: assert property (wr && addr == 8'h64 |=> stage.ncoPhaseLoad && stage.cicClear
    && stage.halfbandClear && !stage.ncoFeedbackEnable && stage.ncoPhaseValue == phase
    ##1 !stage.ncoPhaseLoad && !stage.cicClear && !stage.halfbandClear && stage.ncoFeedbackEnable)
    else $error("test reset strobes");
  test_fifo_a: assert property (wr && addr == 8'h64 |=> fifo.empty && !fifo.full
    && !fifo.ready && !fifo.interrupt && !fifo_interrupt && fifo.depth == 4'h0)
    else $error("test reset fifo flags");
  load_cause_a: assert property (stage.ncoPhaseLoad |-> $past(wr) && $past(addr) == 8'h64)
    else $error("spurious phase load");
  irq_cause_a: assert property ($rose(fifo_interrupt)
    |-> $past(sampleStored) && !$past(fifo.full)) else $error("interrupt without a store");
endmodule : csd_command_decoder_chk

bind csd_command_decoder csd_command_decoder_chk #(.ADDR_W(ADDR_W)) chk_i (.clk(clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .input_sample_clock(input_sample_clock), .sampleStored(sampleStored),
  .fifoThreshold(fifoThreshold), .sync_strobe_out(sync_strobe_out), .fifo(fifo),
  .fifo_interrupt(fifo_interrupt), .stage(stage));

`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the command strobe decoder
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import csd_pkg::*;
;
  localparam logic [14:0] FIFO_IDLE = {3'h7, 3'h0, 4'h0, 4'b1000};
  logic          clk, rst, wr, rd, isc, stored, iscRun, sync, irq;
  logic [7:0]    addr;
  logic [31:0]   wdata, rdata, d;
  logic [2:0]    thr;
  csd_fifo_type  fifo;
  csd_stage_type stage;
  int            failCount, compares, cyc, iscCnt;
  int unsigned   w;

  csd_command_decoder dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .input_sample_clock(isc), .sampleStored(stored), .fifoThreshold(thr),
    .sync_strobe_out(sync), .fifo(fifo), .fifo_interrupt(irq), .stage(stage));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, sample clock of six cycles and hang limit
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (rst)
    begin
      isc    <= 1'b0;
      iscCnt <= 0;
    end
    else if (iscRun)
    begin
      if (iscCnt == 2)
      begin
        isc    <= ~isc;
        iscCnt <= 0;
      end
      else
      begin
        iscCnt <= iscCnt + 1;
      end
    end
    cyc++;
    if (cyc == 2000)
    begin
      $display("[FAIL] %0t run did not finish in time", $time);
      failCount++;
      finalReport();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare, bus access, sample store and final report tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : bus_rd
  task automatic store(input int n);
    repeat (n)
    begin
      @(posedge clk);
      stored <= 1'b1;
      @(posedge clk);
      stored <= 1'b0;
    end
  endtask : store
  task automatic finalReport;
    $display("compares %0d failCount %0d", compares, failCount);
    if (failCount == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finalReport

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rst, wr, rd, stored, iscRun} = 5'b10000;
    addr  = 8'h00;
    wdata = 32'h0;
    thr   = 3'h2;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus_rd(8'h7C, d);
    chk(d, 32'h0000_4407);
    store(3);
    bus_rd(8'h7C, d);
    chk(d, 32'h0000_70DF);
    chk({31'h0, irq}, 32'h1);
    bus_wr(8'h5C, 32'hFFFF_FFFF);
    bus_rd(8'h7C, d);
    chk(d, 32'h0000_5098);
    bus_wr(8'h58, 32'hA5A5_A5A5);
    chk({17'h0, fifo}, {17'h0, FIFO_IDLE});
    bus_wr(8'h5C, 32'h0);
    chk({17'h0, fifo}, {17'h0, FIFO_IDLE});
    @(posedge clk) thr <= 3'h7;
    store(9);
    bus_rd(8'h7C, d);
    chk(d, 32'h0000_7A07);
    bus_wr(8'h70, 32'h0000_02B5);
    bus_rd(8'h70, d);
    chk(d, 32'h0000_02B5);
    bus_wr(8'h64, 32'h1234_5678);
    chk({18'h0, stage}, {18'h0, 1'b1, 10'h2B5, 3'b011});
    chk({17'h0, fifo}, {17'h0, FIFO_IDLE});
    @(posedge clk);
    #1;
    chk({18'h0, stage}, {18'h0, 1'b0, 10'h2B5, 3'b100});
    bus_wr(8'h60, 32'h0);
    chk({31'h0, sync}, 32'h1);
    @(posedge clk);
    #1;
    chk({31'h0, sync}, 32'h0);
    bus_wr(8'h00, 32'h0000_0008);
    bus_rd(8'h00, d);
    chk(d, 32'h0000_0008);
    bus_wr(8'h60, 32'h0);
    repeat (6)
    begin
      @(posedge clk);
      #1;
      chk({31'h0, sync}, 32'h0);
    end
    @(posedge clk) iscRun <= 1'b1;
    w = 0;
    while (sync !== 1'b1 && w < 40)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    w = 0;
    while (sync === 1'b1 && w < 40)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    chk(w, 32'd6);
    @(posedge clk) iscRun <= 1'b0;
    bus_wr(8'h00, 32'h0);
    bus_rd(8'h61, d);
    chk(d, 32'h0);
    bus_rd(8'h5C, d);
    chk(d, 32'h0);
    @(posedge clk);
    #1;
    chk(rdata, 32'h0);
    finalReport();
  end
endmodule : tb_top

`default_nettype wire
